//--- src/converter_alarm_monitor.sv
/*
 Alarm monitor of a multi-channel converter: sticky alarm status, mask,
 fault pin, automatic output shut-off, parity and pattern checks, clock
 supervision, with an AXI4-Lite register slave.
 Assumes FIFO pointers and captured data words arrive synchronous to
 clk_sys; clock toggles and the lock level arrive asynchronous.
*/
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "alarm_monitor_params.svh"

module converter_alarm_monitor #(
	parameter int PTR_DEPTH = 8,
	parameter int CLK_GONE_CYC = `AM_CLK_GONE_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	// AXI4-Lite slave
	input wire logic [`AM_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [`AM_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Monitored conditions
	input wire logic [PTR_DEPTH-1:0] wrPtr,
	input wire logic [PTR_DEPTH-1:0] rdPtr,
	input wire logic dacClkToggle,
	input wire logic dataClkToggle,
	input wire logic pllLocked,
	input wire alarm_monitor_pkg::data_word_s riseWord,
	input wire logic riseValid,
	input wire alarm_monitor_pkg::data_word_s fallWord,
	input wire logic fallValid,
	input wire logic transmit_enable_pin,
	// Outputs
	output logic alarmPin,
	output logic dacOutEnable
);

	localparam int STW = $bits(alarm_monitor_pkg::alarm_status_s);
	localparam int GW = $clog2(CLK_GONE_CYC + 1);

	// Refuse sizes the pointer and supervision logic cannot serve
	if (PTR_DEPTH < 5 || CLK_GONE_CYC < 2) begin : g_badParam
		$error("converter_alarm_monitor: parameter out of range");
	end

	alarm_monitor_pkg::alarm_status_s alarm_status_reg_q;
	alarm_monitor_pkg::alarm_status_s statusSet;
	logic [STW-1:0] alarm_mask_reg_q;
	alarm_monitor_pkg::shutoff_cfg_s auto_shutoff_cfg_reg_q;
	alarm_monitor_pkg::ctrl_s ctrl_q;
	logic [31:0] key_q;

	// Parity of a vector against the selected sense
	function automatic logic parBad(input logic [32:0] v, input logic odd);
		parBad = (^v) != odd;
	endfunction : parBad

	// Rotate a one-hot pointer by a number of places
	function automatic logic [PTR_DEPTH-1:0] rot(
		input logic [PTR_DEPTH-1:0] p, input int n);
		rot = (p << n) | (p >> (PTR_DEPTH - n));
	endfunction : rot

	// Level synchronisers for the foreign-domain signals
	logic [2:0] syncA_q;
	logic [2:0] syncB_q;
	logic [1:0] clkSeen_q;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			syncA_q <= 3'h0;
			syncB_q <= 3'h0;
			clkSeen_q <= 2'h0;
		end else begin
			syncA_q <= {dacClkToggle, dataClkToggle, ~pllLocked};
			syncB_q <= syncA_q;
			clkSeen_q <= syncB_q[2:1];
		end
	end

	// Toggle watchdogs, one per supervised clock
	logic [1:0] clkGone;
	for (genvar g = 0; g < 2; g++) begin : g_clkWatch
		logic [GW-1:0] idle_q;
		always_ff @(posedge clk_sys or negedge rst_b) begin
			if (!rst_b) begin
				idle_q <= '0;
			end else if (syncB_q[g+1] != clkSeen_q[g]) begin
				idle_q <= '0;
			end else if (idle_q != GW'(CLK_GONE_CYC)) begin
				idle_q <= idle_q + GW'(1);
			end
		end
		assign clkGone[g] = idle_q == GW'(CLK_GONE_CYC);
	end

	// FIFO pointer distance checks on one-hot pointers
	logic fifoColl;
	logic fifoOne;
	logic fifoTwo;
	assign fifoColl = |(wrPtr & rdPtr);
	assign fifoOne = fifoColl | |(wrPtr & rot(rdPtr, 1))
		| |(wrPtr & rot(rdPtr, PTR_DEPTH - 1));
	assign fifoTwo = fifoOne | |(wrPtr & rot(rdPtr, 2))
		| |(wrPtr & rot(rdPtr, PTR_DEPTH - 2));

	// Parity paths: single mode checks 33 bits per edge, dual two 17-bit
	logic [3:0] parErr;
	always_comb begin
		parErr = 4'h0;
		if (ctrl_q.parityEna && !ctrl_q.dualParity) begin
			parErr[0] = riseValid
				&& parBad({riseWord.word, riseWord.parity}, ctrl_q.oddParity);
			parErr[1] = fallValid
				&& parBad({fallWord.word, fallWord.parity}, ctrl_q.oddParity);
		end else if (ctrl_q.parityEna) begin
			parErr[0] = riseValid && parBad({16'h0000, riseWord.word[15:0],
				riseWord.strobe}, ctrl_q.oddParity);
			parErr[1] = fallValid && parBad({16'h0000, fallWord.word[15:0],
				fallWord.strobe}, ctrl_q.oddParity);
			parErr[2] = riseValid && parBad({16'h0000, riseWord.word[31:16],
				riseWord.parity}, ctrl_q.oddParity);
			parErr[3] = fallValid && parBad({16'h0000, fallWord.word[31:16],
				fallWord.parity}, ctrl_q.oddParity);
		end
	end

	// Alarm events raised this cycle
	always_comb begin
		statusSet = '0;
		statusSet.zeroChk = wrPtr == '0;
		statusSet.fifoCollision = fifoColl;
		statusSet.fifoOneApart = fifoOne;
		statusSet.fifoTwoApart = fifoTwo;
		statusSet.fifoSummary = fifoTwo;
		statusSet.dacClkGone = clkGone[1];
		statusSet.dataClkGone = clkGone[0];
		statusSet.clkGone = |clkGone;
		statusSet.pllUnlock = syncB_q[0];
		statusSet.ioTest = ctrl_q.ioTestEna
			&& ((riseValid && riseWord.word != key_q)
			|| (fallValid && fallWord.word != key_q));
		{statusSet.parD, statusSet.parC, statusSet.parB, statusSet.parA}
			= parErr;
	end

	// AXI write channel: address and data taken together
	logic wrGo;
	logic [31:0] strbMask;
	assign wrGo = awvalid && wvalid && !awready && !bvalid;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			strbMask[i*8 +: 8] = {8{wstrb[i]}};
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `AM_RESP_OKAY;
		end else begin
			awready <= wrGo;
			wready <= wrGo;
			if (wrGo) begin
				bvalid <= 1'b1;
				bresp <= (awaddr > `AM_OFS_LIVE || awaddr[1:0] != 2'h0)
					? `AM_RESP_SLVERR : `AM_RESP_OKAY;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Sticky status: zeros written clear, a new event wins over the clear
	logic stWr;
	assign stWr = wrGo && awaddr == `AM_OFS_STATUS;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			alarm_status_reg_q <= `AM_RST_STATUS;
		end else if (stWr) begin
			alarm_status_reg_q <= (alarm_status_reg_q
				& STW'(~strbMask | wdata)) | statusSet;
		end else begin
			alarm_status_reg_q <= alarm_status_reg_q | statusSet;
		end
	end

	// Software-written configuration registers
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			alarm_mask_reg_q <= `AM_RST_MASK;
			auto_shutoff_cfg_reg_q <= `AM_RST_SHUTOFF;
			ctrl_q <= `AM_RST_CTRL;
			key_q <= `AM_RST_KEY;
		end else if (wrGo) begin
			case (awaddr)
				`AM_OFS_MASK: begin
					alarm_mask_reg_q <= STW'((alarm_mask_reg_q & ~strbMask)
						| (wdata & strbMask));
				end
				`AM_OFS_SHUTOFF: begin
					if (wstrb[0]) begin
						auto_shutoff_cfg_reg_q <= wdata[1:0];
					end
				end
				`AM_OFS_CTRL: begin
					if (wstrb[0]) begin
						ctrl_q <= wdata[4:0];
					end
				end
				`AM_OFS_KEY: begin
					key_q <= (key_q & ~strbMask) | (wdata & strbMask);
				end
				default: begin
				end
			endcase
		end
	end

	// AXI read channel: one-cycle accept, data on the same edge as the accept
	logic [31:0] rdMux;
	always_comb begin
		rdMux = 32'h0000_0000;
		case (araddr)
			`AM_OFS_STATUS: rdMux = 32'(alarm_status_reg_q);
			`AM_OFS_MASK: rdMux = 32'(alarm_mask_reg_q);
			`AM_OFS_SHUTOFF: rdMux = 32'(auto_shutoff_cfg_reg_q);
			`AM_OFS_CTRL: rdMux = 32'(ctrl_q);
			`AM_OFS_KEY: rdMux = key_q;
			`AM_OFS_LIVE: rdMux = 32'({alarmPin, dacOutEnable});
			default: rdMux = 32'h0000_0000;
		endcase
	end

	logic rdGo;
	assign rdGo = arvalid && !arready && !rvalid;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `AM_RESP_OKAY;
		end else begin
			arready <= rdGo;
			if (rdGo) begin
				rvalid <= 1'b1;
				rdata <= rdMux;
				rresp <= (araddr > `AM_OFS_LIVE || araddr[1:0] != 2'h0)
					? `AM_RESP_SLVERR : `AM_RESP_OKAY;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// Fault pin and output enable with automatic shut-off
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			alarmPin <= 1'b0;
			dacOutEnable <= 1'b0;
		end else begin
			alarmPin <= |(alarm_status_reg_q & alarm_mask_reg_q);
			dacOutEnable <= transmit_enable_pin && ctrl_q.sifTxEnable
				&& !ctrl_q.ioTestEna
				&& !(auto_shutoff_cfg_reg_q.onClockGone
				&& alarm_status_reg_q.clkGone)
				&& !(auto_shutoff_cfg_reg_q.onCollision
				&& alarm_status_reg_q.fifoCollision);
		end
	end

	// Checks on the alarm behaviour
	property p_sticky;
		@(posedge clk_sys) disable iff (!rst_b)
		!stWr |=> (alarm_status_reg_q & $past(alarm_status_reg_q))
			== $past(alarm_status_reg_q);
	endproperty
	a_sticky: assert property (p_sticky) else $error("status bit lost");

	property p_zero;
		@(posedge clk_sys) disable iff (!rst_b)
		wrPtr == '0 |=> alarm_status_reg_q.zeroChk;
	endproperty
	a_zero: assert property (p_zero) else $error("zero check missed");

	property p_coll;
		@(posedge clk_sys) disable iff (!rst_b)
		|(wrPtr & rdPtr) |=> alarm_status_reg_q.fifoCollision
			&& alarm_status_reg_q.fifoOneApart
			&& alarm_status_reg_q.fifoSummary;
	endproperty
	a_coll: assert property (p_coll) else $error("collision missed");

	property p_two;
		@(posedge clk_sys) disable iff (!rst_b)
		|(wrPtr & (rot(rdPtr, 2) | rot(rdPtr, PTR_DEPTH - 2)))
			|=> alarm_status_reg_q.fifoTwoApart;
	endproperty
	a_two: assert property (p_two) else $error("two apart missed");

	property p_one;
		@(posedge clk_sys) disable iff (!rst_b)
		|(wrPtr & (rot(rdPtr, 1) | rot(rdPtr, PTR_DEPTH - 1)))
			|=> alarm_status_reg_q.fifoOneApart
			&& alarm_status_reg_q.fifoTwoApart;
	endproperty
	a_one: assert property (p_one) else $error("one apart missed");

	property p_pll;
		@(posedge clk_sys) disable iff (!rst_b)
		!pllLocked [*3] |=> alarm_status_reg_q.pllUnlock;
	endproperty
	a_pll: assert property (p_pll) else $error("pll alarm missed");

	property p_clk;
		@(posedge clk_sys) disable iff (!rst_b)
		$rose(alarm_status_reg_q.dacClkGone)
			|| $rose(alarm_status_reg_q.dataClkGone)
			|-> alarm_status_reg_q.clkGone;
	endproperty
	a_clk: assert property (p_clk) else $error("clock summary missed");

	property p_pin;
		@(posedge clk_sys) disable iff (!rst_b)
		##1 alarmPin == |$past(alarm_status_reg_q & alarm_mask_reg_q);
	endproperty
	a_pin: assert property (p_pin) else $error("fault pin wrong");

	property p_shut;
		@(posedge clk_sys) disable iff (!rst_b)
		auto_shutoff_cfg_reg_q.onCollision
			&& alarm_status_reg_q.fifoCollision |=> !dacOutEnable;
	endproperty
	a_shut: assert property (p_shut) else $error("shut-off missed");

	property p_parA;
		@(posedge clk_sys) disable iff (!rst_b)
		ctrl_q.parityEna && !ctrl_q.dualParity && riseValid
			&& ((^{riseWord.word, riseWord.parity}) != ctrl_q.oddParity)
			|=> alarm_status_reg_q.parA;
	endproperty
	a_parA: assert property (p_parA) else $error("parity A missed");

	c_write: cover property (@(posedge clk_sys) disable iff (!rst_b)
		stWr ##[1:4] bvalid && bready);
	c_pin: cover property (@(posedge clk_sys) disable iff (!rst_b)
		alarmPin ##[1:20] !alarmPin);
	c_shut: cover property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(dacOutEnable) && alarm_status_reg_q.clkGone);

endmodule : converter_alarm_monitor
`default_nettype wire

//--- src/alarm_monitor_params.svh
/*
 Register offsets, reset values and timing figures of the alarm monitor.
 Assumes inclusion by bare name from the alarm monitor files.
*/
`ifndef ALARM_MONITOR_PARAMS_SVH
`define ALARM_MONITOR_PARAMS_SVH

// Register byte offsets on the AXI4-Lite bus
`define AM_ADDR_W 8
`define AM_OFS_STATUS 8'h00
`define AM_OFS_MASK 8'h04
`define AM_OFS_SHUTOFF 8'h08
`define AM_OFS_CTRL 8'h0c
`define AM_OFS_KEY 8'h10
`define AM_OFS_LIVE 8'h14

// Reset values
`define AM_RST_STATUS 14'h0000
`define AM_RST_MASK 14'h3fff
`define AM_RST_SHUTOFF 2'h0
`define AM_RST_CTRL 5'h00
`define AM_RST_KEY 32'h7a7a7a7a

// AXI response codes
`define AM_RESP_OKAY 2'h0
`define AM_RESP_SLVERR 2'h2

// Clock supervision: a clock with no toggle for this long is gone
`define AM_CLK_PERIOD_NS 10
`define AM_CLK_GONE_NS 640
`define AM_CLK_GONE_CYC (`AM_CLK_GONE_NS / `AM_CLK_PERIOD_NS)

// Pipeline depth of the level synchronisers
`define AM_SYNC_STAGES 2

`endif

//--- src/alarm_monitor_pkg.sv
/*
 Types shared by the alarm monitor: status word layout, control fields
 and captured data words. Assumes nothing of its surroundings.
*/
`default_nettype none
package alarm_monitor_pkg;

	// Sticky alarm status word, bit 13 first from the top
	typedef struct packed {
		logic parD;
		logic parC;
		logic parB;
		logic parA;
		logic pllUnlock;
		logic dataClkGone;
		logic ioTest;
		logic dacClkGone;
		logic clkGone;
		logic fifoCollision;
		logic fifoOneApart;
		logic fifoTwoApart;
		logic fifoSummary;
		logic zeroChk;
	} alarm_status_s;

	// Automatic output shut-off selections
	typedef struct packed {
		logic onCollision;
		logic onClockGone;
	} shutoff_cfg_s;

	// Software control bits
	typedef struct packed {
		logic sifTxEnable;
		logic ioTestEna;
		logic oddParity;
		logic dualParity;
		logic parityEna;
	} ctrl_s;

	// One data word captured on one data clock edge
	typedef struct packed {
		logic [31:0] word;
		logic parity;
		logic strobe;
	} data_word_s;

endpackage : alarm_monitor_pkg
`default_nettype wire

//--- testbench/alarm_source_model.sv
/*
 Behavioural source of the converter sample clock, the data clock and the
 multiplier lock level. Assumes the bench clock as its time base and a
 three-bit run control from the bench: bit 0 sample clock, bit 1 data
 clock, bit 2 lock.
*/
`timescale 1ns/1ps
`default_nettype none
module alarm_source_model (
	input wire logic clk,
	input wire logic [2:0] ctl,
	output logic dacClkToggle,
	output logic dataClkToggle,
	output logic pllLocked
);
	// Known levels before the first edge
	initial begin
		dacClkToggle = 1'b0;
		dataClkToggle = 1'b0;
	end

	// A running clock toggles each cycle, a stopped one stands still
	always @(posedge clk) begin
		if (ctl[0]) begin
			dacClkToggle <= !dacClkToggle;
		end
		if (ctl[1]) begin
			dataClkToggle <= !dataClkToggle;
		end
	end

	// Lock level follows the control directly
	assign pllLocked = ctl[2];
endmodule : alarm_source_model
`default_nettype wire

//--- testbench/converter_alarm_monitor_tb.sv
/*
 Self-checking bench of the alarm monitor: AXI4-Lite tasks and alarm
 scenarios. Assumes the design package, the parameter header and the
 clock source model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "alarm_monitor_params.svh"
module converter_alarm_monitor_tb;
	logic clk_sys, rst_b, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, riseValid, fallValid;
	logic txPin, alarmPin, dacOutEnable, dacTog, dataTog, lockLvl;
	logic [7:0] awaddr, araddr, wrPtr, rdPtr;
	logic [31:0] wdata, rdata, rv;
	logic [1:0] bresp, rresp, rr;
	logic [2:0] ctl;
	alarm_monitor_pkg::data_word_s riseWord, fallWord;
	int errors, cmpCount;

	converter_alarm_monitor #(.PTR_DEPTH(8), .CLK_GONE_CYC(4)) DUT (
		.clk_sys(clk_sys), .rst_b(rst_b), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .wrPtr(wrPtr),
		.rdPtr(rdPtr), .dacClkToggle(dacTog), .dataClkToggle(dataTog),
		.pllLocked(lockLvl), .riseWord(riseWord), .riseValid(riseValid),
		.fallWord(fallWord), .fallValid(fallValid),
		.transmit_enable_pin(txPin), .alarmPin(alarmPin),
		.dacOutEnable(dacOutEnable));

	alarm_source_model src (.clk(clk_sys), .ctl(ctl),
		.dacClkToggle(dacTog), .dataClkToggle(dataTog),
		.pllLocked(lockLvl));

	// Free-running 100 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = !clk_sys;
	end

	task test_done;
		$display("compares %0d mismatches %0d", cmpCount, errors);
		if (errors == 0 && cmpCount > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done

	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmpCount++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask : cmp

	// Cuts a hung handshake short
	task hang(input int n);
		if (n > 200) begin
			errors++;
			$display("unexpected handshake timeout exp 1 got 0");
			test_done();
		end
	endtask : hang

	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc

	// Address and data offered together, held until taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic awDone;
		logic wDone;
		n = 0;
		awDone = 1'b0;
		wDone = 1'b0;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// Each channel is released once its own ready is seen
		while (!(awDone && wDone)) begin
			@(posedge clk_sys);
			n++;
			hang(n);
			if (!awDone && awready === 1'b1) begin
				awDone = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wDone && wready === 1'b1) begin
				wDone = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) begin
			@(posedge clk_sys);
			n++;
			hang(n);
		end
		rr = bresp;
		bready <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			hang(n);
		end while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) begin
			@(posedge clk_sys);
			n++;
			hang(n);
		end
		rv = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask : rd

	// Cause active: status set, a clearing write does not drop it
	task hit(input logic [31:0] e);
		cyc(12);
		rd(`AM_OFS_STATUS);
		cmp("status", e, rv);
		wr(`AM_OFS_STATUS, 32'h0);
		rd(`AM_OFS_STATUS);
		cmp("status held", e, rv);
	endtask : hit

	// Cause gone: a clearing write leaves the status clean
	task heal;
		cyc(12);
		wr(`AM_OFS_STATUS, 32'h0);
		rd(`AM_OFS_STATUS);
		cmp("status clear", 32'h0, rv);
		cmp("pin clear", 32'h0, alarmPin);
	endtask : heal

	// Main sequence
	initial begin
		rst_b = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{riseValid, fallValid} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wrPtr = 8'h01;
		rdPtr = 8'h10;
		ctl = 3'h7;
		txPin = 1'b1;
		riseWord = '0;
		fallWord = '0;
		errors = 0;
		cmpCount = 0;
		cyc(6);
		rst_b <= 1'b1;
		rd(`AM_OFS_MASK);
		cmp("mask reset", 32'h3fff, rv);
		rd(`AM_OFS_KEY);
		cmp("key reset", 32'h7a7a7a7a, rv);
		rd(8'h18);
		cmp("rresp", 32'h2, rr);
		wr(8'h18, 32'h0);
		cmp("bresp", 32'h2, rr);
		heal();
		$display("reset test done");
		wr(`AM_OFS_SHUTOFF, 32'h2);
		wr(`AM_OFS_CTRL, 32'h10);
		cyc(2);
		cmp("out enable on", 32'h1, dacOutEnable);
		txPin <= 1'b0;
		cyc(2);
		cmp("out enable pin low", 32'h0, dacOutEnable);
		txPin <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			rdPtr <= 8'h01 << k;
			hit((32'h1e >> k) & 32'h1e);
			cmp("pin", 32'h1, alarmPin);
			cmp("out enable", k != 0, dacOutEnable);
			rdPtr <= 8'h10;
			heal();
		end
		wrPtr <= 8'h00;
		cyc(12);
		rd(`AM_OFS_STATUS);
		cmp("zero check", 32'h1, rv & 32'h1);
		wrPtr <= 8'h01;
		rdPtr <= 8'h10;
		heal();
		$display("fifo test done");
		wr(`AM_OFS_MASK, 32'h0);
		rdPtr <= 8'h01;
		hit(32'h1e);
		cmp("pin masked", 32'h0, alarmPin);
		wr(`AM_OFS_MASK, 32'h10);
		cyc(2);
		cmp("pin unmasked", 32'h1, alarmPin);
		rdPtr <= 8'h10;
		heal();
		wr(`AM_OFS_MASK, 32'h3fff);
		wr(`AM_OFS_SHUTOFF, 32'h3);
		$display("mask test done");
		for (int i = 0; i < 3; i++) begin
			ctl <= ~(3'h1 << i);
			hit(i == 0 ? 32'h60 : i == 1 ? 32'h120 : 32'h200);
			cmp("clock out enable", i == 2, dacOutEnable);
			ctl <= 3'h7;
			heal();
		end
		$display("clock test done");
		for (int i = 0; i < 4; i++) begin
			wr(`AM_OFS_CTRL, i < 2 ? 32'h11 : 32'h13);
			riseWord <= {(i < 2 ? 32'h1 : 32'h10000), 2'b00};
			fallWord <= {(i < 2 ? 32'h1 : 32'h10000), 2'b00};
			riseValid <= !i[0];
			fallValid <= i[0];
			hit(32'h400 << i);
			riseValid <= 1'b0;
			fallValid <= 1'b0;
			heal();
		end
		$display("parity test done");
		wr(`AM_OFS_CTRL, 32'h18);
		riseWord <= '0;
		riseValid <= 1'b1;
		@(posedge clk_sys);
		riseValid <= 1'b0;
		cyc(12);
		rd(`AM_OFS_STATUS);
		cmp("pattern", 32'h80, rv);
		cmp("test out enable", 32'h0, dacOutEnable);
		heal();
		$display("pattern test done");
		test_done();
	end
endmodule : converter_alarm_monitor_tb
`default_nettype wire
